// ===== inc/mmd_consts.vh
/*
 Constants for the memory map and stack decode block: register addresses,
 reset values, field positions and region bounds.
 Assumes inclusion by bare name from files under src/ and verif/.
*/
`ifndef MMD_CONSTS_VH
`define MMD_CONSTS_VH
`define MMD_ADDR_SP_LOW      8'h81
`define MMD_ADDR_SP_HIGH     8'hb7
`define MMD_ADDR_CFG         8'haf
`define MMD_SP_RESET         8'h07
`define MMD_SPH_RESET        8'h00
`define MMD_CFG_RESET        8'h00
`define MMD_CFG_XSTACK_BIT   7
`define MMD_CFG_EXTENDED_DATA_RAM_BIT     0
`define MMD_CODE_NOP_BASE    16'hf800
`define MMD_CODE_WRITE_TOP   16'hdfff
`define MMD_NOP_OPCODE       8'h00
`define MMD_SFR_BASE         8'h80
`define MMD_BANK_TOP         8'h1f
`define MMD_BIT_BASE         8'h20
`define MMD_BIT_TOP          8'h2f
`define MMD_EXTENDED_DATA_RAM_TOP         24'h0007ff
`define MMD_NVD_ADDR_LO      8'hc0
`define MMD_NVD_ADDR_HI      8'hc7
`endif

// ===== src/mmd_decode.v
/*
 Memory map and stack decode for a small microcontroller core: code source
 select, internal RAM region decode, 8/11-bit stack pointer, and the mapping
 of on-chip extended RAM into a 24-bit external data space.
 Assumes core requests are on ref_clk; ext_code_select_n is a pin.
*/
//
// Contract
// - Low external-access pin at reset release selects external code fetch.
// - Internal fetches at F800H..FFFFH return no-operation opcodes, never roll over.
// - 56 kB of program memory may be rewritten while running.
// - Lower 128 RAM bytes reachable by direct and indirect addressing.
// - Upper 128 RAM bytes indirect only; direct there selects special registers.
// - Lowest 32 bytes form four banks of eight working registers.
// - Bytes 20H..2FH are addressable as 128 single bits.
// - Reset loads pointer 07H; pre-increment before push, first at 08H.
// - Extended stack off: pointer is 8 bits, wraps FFH to 00H.
// - Config bit 7 set: pointer is 11 bits, 00FFH continues to 0100H.
// - Up to 1792 extended RAM bytes serve as stack, 2048 total.
// - Low pointer byte at 81H; high byte at B7H, three low bits used.
// - External data move drives all needed strobes itself.
// - External data space is 16 MB with 24-bit address.
// - Config bit 0 maps 2 kB extended RAM at bottom; else all off-chip.
// - On-chip extended RAM accesses leave the address/data port free.
// - Nonvolatile data memory reached only through special-register window.
// - Address-latch strobe marks low and page address bytes externally.
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.vh"
module mmd_decode
(
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        ext_code_select_n,
   input  wire [15:0] fetch_addr,
   input  wire        fetch_req,
   input  wire [7:0]  code_rom_data,
   input  wire [7:0]  ext_code_data,
   input  wire [15:0] prog_wr_addr,
   input  wire        prog_wr_req,
   input  wire [7:0]  ram_addr,
   input  wire        ram_indirect,
   input  wire        sfr_wr,
   input  wire        sfr_rd,
   input  wire [7:0]  sfr_wdata,
   input  wire        push,
   input  wire        pop,
   input  wire        xmove_req,
   input  wire        xmove_wr,
   input  wire [23:0] xmove_addr,
   input  wire [7:0]  xmove_wdata,
   input  wire [7:0]  ext_data_in,
   output reg         code_external,
   output reg  [7:0]  fetch_data,
   output reg         prog_wr_ok,
   output reg         sel_iram,
   output reg         sel_sfr,
   output reg         sel_bank_reg,
   output reg  [1:0]  bank_num,
   output reg  [2:0]  bank_reg_num,
   output reg         sel_bit_area,
   output reg         sel_nvdata_ctl,
   output reg  [7:0]  sfr_rdata,
   output reg  [10:0] stack_addr,
   output reg         stack_in_extended_data_ram,
   output reg  [7:0]  xmove_rdata,
   output reg         xmove_done,
   output reg         ale,
   output reg         rd_n,
   output reg         wr_n,
   output reg  [7:0]  addr_page_out,
   output reg  [7:0]  addr_high_out,
   output reg  [7:0]  ad_out,
   output reg         ad_oe_n,
   output reg         port_bus_busy
);
   localparam ST_IDLE  = 5'b00001;
   localparam ST_ALE   = 5'b00010;
   localparam ST_STRB  = 5'b00100;
   localparam ST_DONE  = 5'b01000;
   localparam ST_IRAM  = 5'b10000;

   reg        ea_s1_reg;
   reg        ea_s2_reg;
   reg        rst_d_reg;
   reg [7:0]  sp_low_reg;
   reg [7:0]  sp_high_reg;
   reg [7:0]  cfg_reg;
   reg [4:0]  st_reg;
   reg        wr_hold_reg;
   reg [7:0]  wdat_hold_reg;
   reg [10:0] sp_full;
   reg [10:0] sp_inc;
   reg [10:0] sp_dec;
   wire       xstack_en;
   wire       extended_data_ram_map;
   wire       in_extended_data_ram;
   wire [7:0] extended_data_ram_rdata;

   // True when a data-space address falls into the on-chip extended RAM
   function is_onchip;
      input [23:0] a;
      input        en;
      begin
         is_onchip = en && (a <= `MMD_EXTENDED_DATA_RAM_TOP);
      end
   endfunction

   assign xstack_en = cfg_reg[`MMD_CFG_XSTACK_BIT];
   assign extended_data_ram_map  = cfg_reg[`MMD_CFG_EXTENDED_DATA_RAM_BIT];
   assign in_extended_data_ram   = is_onchip(xmove_addr, extended_data_ram_map);

   // Pin synchroniser, then code source caught on the cycle after reset
   always @(posedge ref_clk)
   begin
      ea_s1_reg <= ext_code_select_n;
      ea_s2_reg <= ea_s1_reg;
      rst_d_reg <= rst;
      if (rst)
         code_external <= 1'b0;
      else if (rst_d_reg)
         code_external <= ~ea_s2_reg;
   end

   // Code fetch path; the top 2 kB reads as no-operation only for internal fetches, external fetches pass ext_code_data
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         fetch_data <= `MMD_NOP_OPCODE;
         prog_wr_ok <= 1'b0;
      end
      else
      begin
         if (fetch_req)
         begin
            if (code_external)
               fetch_data <= ext_code_data;
            else if (fetch_addr >= `MMD_CODE_NOP_BASE)
               fetch_data <= `MMD_NOP_OPCODE;
            else
               fetch_data <= code_rom_data;
         end
         prog_wr_ok <= prog_wr_req && (prog_wr_addr <= `MMD_CODE_WRITE_TOP);
      end
   end

   // Internal RAM and special register decode, registered for the core
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         sel_iram       <= 1'b0;
         sel_sfr        <= 1'b0;
         sel_bank_reg   <= 1'b0;
         bank_num       <= 2'h0;
         bank_reg_num   <= 3'h0;
         sel_bit_area   <= 1'b0;
         sel_nvdata_ctl <= 1'b0;
      end
      else
      begin
         sel_sfr  <= !ram_indirect && (ram_addr >= `MMD_SFR_BASE);
         sel_iram <= ram_indirect || (ram_addr < `MMD_SFR_BASE);
         sel_bank_reg <= (ram_addr <= `MMD_BANK_TOP);
         bank_num     <= ram_addr[4:3];
         bank_reg_num <= ram_addr[2:0];
         sel_bit_area <= (ram_addr >= `MMD_BIT_BASE) && (ram_addr <= `MMD_BIT_TOP);
         // Nonvolatile data is only a register window, never a memory map
         sel_nvdata_ctl <= !ram_indirect && (ram_addr >= `MMD_NVD_ADDR_LO)
                           && (ram_addr <= `MMD_NVD_ADDR_HI);
      end
   end

   // Pointer arithmetic; the 8-bit mode masks the high bits so it wraps
   always @*
   begin
      sp_full = {sp_high_reg[2:0], sp_low_reg};
      sp_inc  = sp_full + 11'h001;
      sp_dec  = sp_full - 11'h001;
      if (!xstack_en)
      begin
         sp_inc = {3'h0, sp_inc[7:0]};
         sp_dec = {3'h0, sp_dec[7:0]};
      end
   end

   // Stack pointer and config registers
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         sp_low_reg  <= `MMD_SP_RESET;
         sp_high_reg <= `MMD_SPH_RESET;
         cfg_reg     <= `MMD_CFG_RESET;
         stack_addr  <= 11'h000;
         stack_in_extended_data_ram <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            sp_low_reg  <= sp_inc[7:0];
            sp_high_reg <= {5'h00, sp_inc[10:8]};
            stack_addr  <= sp_inc;
            stack_in_extended_data_ram <= (sp_inc[10:8] != 3'h0);
         end
         else if (pop)
         begin
            sp_low_reg  <= sp_dec[7:0];
            sp_high_reg <= {5'h00, sp_dec[10:8]};
            stack_addr  <= sp_full;
            stack_in_extended_data_ram <= (sp_full[10:8] != 3'h0);
         end
         else if (sfr_wr)
         begin
            if (ram_addr == `MMD_ADDR_SP_LOW)
               sp_low_reg <= sfr_wdata;
            if (ram_addr == `MMD_ADDR_SP_HIGH)
               sp_high_reg <= {5'h00, sfr_wdata[2:0]};
            if (ram_addr == `MMD_ADDR_CFG)
               cfg_reg <= sfr_wdata;
         end
      end
   end

   // Register read-back
   always @(posedge ref_clk)
   begin
      if (rst)
         sfr_rdata <= 8'h00;
      else if (sfr_rd)
      begin
         case (ram_addr)
            `MMD_ADDR_SP_LOW:  sfr_rdata <= sp_low_reg;
            `MMD_ADDR_SP_HIGH: sfr_rdata <= sp_high_reg;
            `MMD_ADDR_CFG:     sfr_rdata <= cfg_reg;
            default:           sfr_rdata <= 8'h00;
         endcase
      end
   end

   // External data move sequencer; strobes generated without core help
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_reg        <= ST_IDLE;
         ale           <= 1'b0;
         rd_n          <= 1'b1;
         wr_n          <= 1'b1;
         addr_page_out <= 8'h00;
         addr_high_out <= 8'h00;
         ad_out        <= 8'hff;
         ad_oe_n       <= 1'b1;
         port_bus_busy <= 1'b0;
         xmove_done    <= 1'b0;
         xmove_rdata   <= 8'h00;
         wr_hold_reg   <= 1'b0;
         wdat_hold_reg <= 8'h00;
      end
      else
      begin
         xmove_done <= 1'b0;
         case (st_reg)
            ST_IDLE:
            begin
               if (xmove_req)
               begin
                  wr_hold_reg   <= xmove_wr;
                  wdat_hold_reg <= xmove_wdata;
                  if (in_extended_data_ram)
                     st_reg <= ST_IRAM;
                  else
                  begin
                     // Page, high and low bytes form the 24-bit address
                     addr_page_out <= xmove_addr[23:16];
                     addr_high_out <= xmove_addr[15:8];
                     ad_out        <= xmove_addr[7:0];
                     ad_oe_n       <= 1'b0;
                     ale           <= 1'b1;
                     port_bus_busy <= 1'b1;
                     st_reg        <= ST_ALE;
                  end
               end
            end
            ST_ALE:
            begin
               ale <= 1'b0;
               rd_n <= wr_hold_reg;
               wr_n <= ~wr_hold_reg;
               ad_out  <= wr_hold_reg ? wdat_hold_reg : 8'hff;
               ad_oe_n <= ~wr_hold_reg;
               st_reg <= ST_STRB;
            end
            ST_STRB:
            begin
               if (!wr_hold_reg)
                  xmove_rdata <= ext_data_in;
               rd_n <= 1'b1;
               wr_n <= 1'b1;
               ad_oe_n <= 1'b1;
               st_reg <= ST_DONE;
            end
            ST_DONE:
            begin
               port_bus_busy <= 1'b0;
               xmove_done <= 1'b1;
               st_reg <= ST_IDLE;
            end
            ST_IRAM:
            begin
               // Port pins untouched; registered RAM data is ready now
               xmove_rdata <= extended_data_ram_rdata;
               xmove_done <= 1'b1;
               st_reg <= ST_IDLE;
            end
            default:
               st_reg <= ST_IDLE;
         endcase
      end
   end

   // On-chip extended RAM shared by data moves (stack traffic goes via core)
   mmd_extended_data_ram #(.AW(11), .DW(8)) u_extended_data_ram
   (
      .ref_clk (ref_clk),
      .we      (xmove_req && xmove_wr && in_extended_data_ram && (st_reg == ST_IDLE)),
      .addr    (xmove_addr[10:0]),
      .wdata   (xmove_wdata),
      .rdata   (extended_data_ram_rdata)
   );
endmodule // mmd_decode
`default_nettype wire

// ===== src/mmd_extended_data_ram.v
/*
 Single-port on-chip extended RAM, registered read data.
 Assumes one request per cycle from the decode block on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module mmd_extended_data_ram
#(
   parameter AW = 11,
   parameter DW = 8
)
(
   input  wire          ref_clk,
   input  wire          we,
   input  wire [AW-1:0] addr,
   input  wire [DW-1:0] wdata,
   output reg  [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Write-first is not needed; read returns old contents
   always @(posedge ref_clk)
   begin
      if (we)
         mem[addr] <= wdata;
      rdata <= mem[addr];
   end
endmodule // mmd_extended_data_ram
`default_nettype wire

// ===== verif/mmd_decode_chk.sv
/*
 Concurrent checks on the ports of mmd_decode.
 Assumes a bind into the design top and the single core clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.vh"
module mmd_decode_chk
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [15:0] fetch_addr,
   input wire logic        fetch_req,
   input wire logic [7:0]  ram_addr,
   input wire logic        ram_indirect,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        push,
   input wire logic        pop,
   input wire logic        xmove_req,
   input wire logic        xmove_wr,
   input wire logic [23:0] xmove_addr,
   input wire logic        code_external,
   input wire logic [7:0]  fetch_data,
   input wire logic        sel_iram,
   input wire logic        sel_sfr,
   input wire logic [10:0] stack_addr,
   input wire logic        xmove_done,
   input wire logic        ale,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic [7:0]  addr_page_out,
   input wire logic [7:0]  addr_high_out,
   input wire logic [7:0]  ad_out,
   input wire logic        ad_oe_n,
   input wire logic        port_bus_busy
);
   logic xs_reg;
   logic xr_reg;
   wire  on_go = xmove_req && !port_bus_busy && xr_reg && xmove_addr <= `MMD_EXTENDED_DATA_RAM_TOP;
   wire  ext_go = xmove_req && !port_bus_busy && !(xr_reg && xmove_addr <= `MMD_EXTENDED_DATA_RAM_TOP);
   // Mirror of config bits 7 and 0; a push or pop at the same edge wins
   always_ff @(posedge ref_clk)
      if (rst)
         {xs_reg, xr_reg} <= 2'b00;
      else if (sfr_wr && !push && !pop && ram_addr == `MMD_ADDR_CFG)
         {xs_reg, xr_reg} <= {sfr_wdata[7], sfr_wdata[0]};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_first_push;
      push && $past(rst) |=> stack_addr == 11'h008;
   endproperty
   a_first_push: assert property (p_first_push) else $error("first push off");
   property p_wrap8;
      push && $past(push) && !xs_reg |=> stack_addr[7:0] == $past(stack_addr[7:0]) + 8'h01;
   endproperty
   a_wrap8: assert property (p_wrap8) else $error("8-bit step wrong");
   property p_wrap11;
      push && $past(push) && xs_reg |=> stack_addr == $past(stack_addr) + 11'h001;
   endproperty
   a_wrap11: assert property (p_wrap11) else $error("11-bit step wrong");
   property p_nop;
      fetch_req && !code_external && fetch_addr >= `MMD_CODE_NOP_BASE |=> fetch_data == 8'h00;
   endproperty
   a_nop: assert property (p_nop) else $error("top fetch not blank");
   property p_direct_sfr;
      1'b1 |=> sel_sfr == (!$past(ram_indirect) && $past(ram_addr[7]));
   endproperty
   a_direct_sfr: assert property (p_direct_sfr) else $error("region select wrong");
   property p_iram;
      1'b1 |=> sel_iram == ($past(ram_indirect) || !$past(ram_addr[7]));
   endproperty
   a_iram: assert property (p_iram) else $error("indirect region select wrong");
   property p_onchip;
      on_go |=> (!ale && rd_n && wr_n && ad_oe_n && !xmove_done)
         ##1 (xmove_done && !ale && rd_n && wr_n && ad_oe_n);
   endproperty
   a_onchip: assert property (p_onchip) else $error("on-chip move touched pins");
   property p_ext_addr;
      ext_go |=> ale && !ad_oe_n && port_bus_busy && addr_page_out == $past(xmove_addr[23:16])
         && addr_high_out == $past(xmove_addr[15:8]) && ad_out == $past(xmove_addr[7:0]);
   endproperty
   a_ext_addr: assert property (p_ext_addr) else $error("address phase wrong");
   property p_ext_strobe;
      ext_go |=> ##1 (!ale && rd_n == $past(xmove_wr, 2) && wr_n == !$past(xmove_wr, 2))
         ##1 (rd_n && wr_n) ##1 (xmove_done && !port_bus_busy);
   endproperty
   a_ext_strobe: assert property (p_ext_strobe) else $error("strobe phase wrong");
endmodule // mmd_decode_chk
bind mmd_decode mmd_decode_chk chk (.*);
`default_nettype wire

// ===== verif/mmd_decode_tb.sv
/*
 Self-checking bench for mmd_decode with an external memory model.
 Assumes the design, the checker and the memory model are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module mmd_decode_tb;
   logic ref_clk = 0, rst = 1, ext_code_select_n = 0, fetch_req = 0, prog_wr_req = 0;
   logic ram_indirect = 0, sfr_wr = 0, sfr_rd = 0, push = 0, pop = 0, xmove_req = 0;
   logic xmove_wr = 0;
   logic [15:0] fetch_addr = 16'h0000, prog_wr_addr = 16'h0000, lfsr_reg = 16'ha4da;
   logic [7:0] code_rom_data = 8'h00, ram_addr = 8'h00, sfr_wdata = 8'h00;
   logic [7:0] xmove_wdata = 8'h00;
   logic [23:0] xmove_addr = 24'h000000;
   wire [7:0] ext_code_data, ext_data_in, fetch_data, sfr_rdata, xmove_rdata;
   wire [7:0] addr_page_out, addr_high_out, ad_out;
   wire [10:0] stack_addr;
   wire [1:0] bank_num;
   wire [2:0] bank_reg_num;
   wire code_external, prog_wr_ok, sel_iram, sel_sfr, sel_bank_reg, sel_bit_area;
   wire sel_nvdata_ctl, stack_in_extended_data_ram, xmove_done, ale, rd_n, wr_n, ad_oe_n, port_bus_busy;
   int n_fail = 0;
   int n_tests = 0;
   logic [8:0] exp_q[$];
   mmd_decode uut (.*);
   mmd_extmem mem (.*);
   always #20 ref_clk = ~ref_clk;
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic special_register_space(input logic w, input logic [7:0] a, input logic [7:0] d);
      {sfr_wr, sfr_rd, ram_addr, sfr_wdata} = {w, !w, a, d};
      tick(1);
      {sfr_wr, sfr_rd} = 2'b00;
      tick(1);
   endtask
   task automatic fet(input logic [15:0] a, input logic [7:0] e);
      {fetch_req, fetch_addr} = {1'b1, a};
      tick(1);
      fetch_req = 0;
      chk(fetch_data, e);
      // Let an edge pass so a following fetch never re-raises the strobe at once
      tick(1);
   endtask
   // Back-to-back stack ops; each answer is checked in its own cycle
   task automatic stk(input logic pu, input logic wide, input int n, input logic [10:0] e);
      {push, pop} = {pu, !pu};
      for (int i = 0; i < n; i++)
      begin
         tick(1);
         chk(stack_addr, e);
         e = !pu ? e - 11'h001 : wide ? e + 11'h001 : {3'h0, e[7:0] + 8'h01};
      end
      {push, pop} = 2'b00;
   endtask
   task automatic xmv(input logic w, input logic [23:0] a, input logic [7:0] d);
      exp_q.push_back({!w, d});
      {xmove_req, xmove_wr, xmove_addr, xmove_wdata} = {1'b1, w, a, d};
      tick(1);
      xmove_req = 0;
      for (int i = 0; i < 8 && xmove_done !== 1'b1; i++)
         tick(1);
      tick(1);
   endtask
   // Completed moves retire notes in order; writes carry no data to compare
   always @(posedge ref_clk)
      if (xmove_done === 1'b1 && exp_q.size() > 0)
      begin
         if (exp_q[0][8])
            chk(xmove_rdata, exp_q[0][7:0]);
         void'(exp_q.pop_front());
      end
   // Watchdog: the whole sequence needs well under a thousand cycles
   initial
   begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      tick(5);
      rst = 0;
      tick(2);
      chk(code_external, 1);
      fet(16'hf900, 8'h5a);
      special_register_space(0, 8'h81, 0);
      chk(sfr_rdata, 8'h07);
      special_register_space(1, 8'hb7, 8'hff);
      special_register_space(0, 8'hb7, 0);
      chk(sfr_rdata, 8'h07);
      ext_code_select_n = 1;
      rst = 1;
      tick(5);
      rst = 0;
      stk(1, 0, 1, 11'h008);
      tick(1);
      chk(code_external, 0);
      special_register_space(0, 8'hb7, 0);
      chk(sfr_rdata, 8'h00);
      code_rom_data = lfsr_reg[7:0];
      fet(16'h0123, code_rom_data);
      fet(16'hf800, 8'h00);
      fet(16'hffff, 8'h00);
      special_register_space(1, 8'h81, 8'hfe);
      stk(1, 0, 2, 11'h0ff);
      special_register_space(1, 8'haf, 8'h81);
      special_register_space(1, 8'h81, 8'hfe);
      stk(1, 1, 3, 11'h0ff);
      chk(stack_in_extended_data_ram, 1);
      special_register_space(0, 8'hb7, 0);
      chk(sfr_rdata, 8'h01);
      stk(0, 1, 2, 11'h101);
      for (int i = 0; i < 2; i++)
      begin
         {prog_wr_req, prog_wr_addr} = {1'b1, 16'hdfff + 16'(i)};
         tick(1);
         prog_wr_req = 0;
         chk(prog_wr_ok, 24'(i == 0));
         tick(1);
      end
      for (int i = 0; i < 24; i++)
      begin
         lfsr_reg = lfsr_next(lfsr_reg);
         {ram_indirect, ram_addr} = lfsr_reg[8:0];
         tick(1);
      end
      {ram_indirect, ram_addr} = 9'h01b;
      tick(1);
      chk({sel_bank_reg, bank_num, bank_reg_num}, 6'h3b);
      ram_addr = 8'h2f;
      tick(1);
      chk(sel_bit_area, 1);
      ram_addr = 8'hc3;
      tick(1);
      chk({sel_nvdata_ctl, sel_sfr, sel_iram}, 3'h6);
      lfsr_reg = lfsr_next(lfsr_reg);
      xmv(1, 24'h0007ff, lfsr_reg[7:0]);
      xmv(0, 24'h0007ff, lfsr_reg[7:0]);
      xmv(1, 24'h123456, lfsr_reg[15:8]);
      xmv(0, 24'h123456, lfsr_reg[15:8]);
      special_register_space(1, 8'haf, 8'h00);
      xmv(0, 24'h000056, lfsr_reg[15:8]);
      chk(exp_q.size(), 0);
      tally_and_finish();
   end
endmodule // mmd_decode_tb
`default_nettype wire

// ===== verif/mmd_extmem.sv
/*
 Behavioural external code and data memory facing mmd_decode.
 Assumes address bytes are valid while the latch strobe is high.
*/
`timescale 1ns/10ps
`default_nettype none
module mmd_extmem
(
   input  wire logic        ref_clk,
   input  wire logic [15:0] fetch_addr,
   input  wire logic        ale,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [7:0]  addr_page_out,
   input  wire logic [7:0]  addr_high_out,
   input  wire logic [7:0]  ad_out,
   input  wire logic        ad_oe_n,
   output wire logic [7:0]  ext_code_data,
   output wire logic [7:0]  ext_data_in
);
   logic [7:0]  mem_reg [256];
   logic [23:0] addr_reg = 24'h000000;
   logic [7:0]  last_reg = 8'h00;
   // Code bytes follow the address so the bench can predict them
   assign ext_code_data = fetch_addr[7:0] ^ 8'h5a;
   // A released bus never shows the last value, it flips every cycle
   assign ext_data_in = !rd_n ? mem_reg[addr_reg[7:0]] : ~last_reg;
   // Only 256 cells: high address bytes alias, which is harsher than a real chip
   always @(posedge ref_clk)
   begin
      last_reg <= ext_data_in;
      if (ale && !ad_oe_n)
         addr_reg <= {addr_page_out, addr_high_out, ad_out};
      if (!wr_n)
         mem_reg[addr_reg[7:0]] <= ad_out;
   end
endmodule // mmd_extmem
`default_nettype wire
